/* hw/alarm_combiner.sv */
// boolean alarm combiners and sag/swell detectors behind an apb slave
// How it works
// - type 100 asserts while all enabled inputs active
// - type 101 asserts unless all enabled inputs active
// - type 102 asserts while any enabled input active
// - type 103 asserts while no enabled input active
// - type 104 asserts while exactly one enabled input active
// - swell picks up after delay above pickup
// - swell drops out after delay below dropout
// - sag picks up after delay below pickup
// - sag drops out after delay above dropout
// - setpoints unsigned, delays in whole line cycles
// - detectors evaluated every half line cycle
// - ten independent combiners, own code and selects
// - twelve independent detectors, own setpoints and delays
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module alarm_combiner
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    // apb slave
    input  wire apb_req_type                     apb_req,
    output logic [DATA_W-1:0]                    prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // metering core
    input  wire logic                            half_cycle_tick,
    input  wire logic [NUM_DET-1:0][RMS_W-1:0]   rms_in,
    input  wire logic [NUM_SRC-1:0]              alarm_src,
    // alarm results
    output logic [NUM_COMB-1:0]                  comb_alarm,
    output logic [NUM_DET-1:0]                   det_alarm,
    output logic                                 irq
);

    typedef struct packed {
        comb_cfg_type [NUM_COMB-1:0] comb_cfg;
        det_cfg_type  [NUM_DET-1:0]  det_cfg;
        logic [NUM_COMB-1:0]         comb_alarm;
        logic [NUM_EV-1:0]           prev_alarm;
        logic [NUM_EV-1:0]           pick_stat;
        logic [NUM_EV-1:0]           pick_mask;
        logic [NUM_EV-1:0]           drop_stat;
        logic [NUM_EV-1:0]           drop_mask;
        logic [DATA_W-1:0]           eval_count;
        logic [DATA_W-1:0]           prdata;
        logic                        pslverr;
    } state_type;

    state_type           state_r;
    state_type           state_nxt;
    logic [NUM_DET-1:0]  det_alarm_w;
    logic [NUM_EV-1:0]   alarm_all;
    logic [NUM_EV-1:0]   rise_ev;
    logic [NUM_EV-1:0]   fall_ev;
    logic [NUM_EV-1:0]   pick_clr;
    logic [NUM_EV-1:0]   drop_clr;
    logic                setup;
    logic                access;
    logic                wr_done;
    logic                rd_done;
    logic [DATA_W-1:0]   rd_data;
    logic                rd_hit;

    // one combiner: count enabled and active inputs, then apply the code
    function automatic logic comb_eval(comb_cfg_type c, logic [NUM_SRC-1:0] src);
        logic [2:0]             n_en;
        logic [2:0]             n_act;
        logic [COMB_INPUTS-1:0] act;
        logic                   res;
        n_en  = 3'h0;
        n_act = 3'h0;
        res   = 1'b0;
        for (int i = 0; i < COMB_INPUTS; i++)
        begin
            act[i] = c.enable[i] & src[c.sel[i]];
            n_en   = n_en + 3'(c.enable[i]);
            n_act  = n_act + 3'(act[i]);
        end
        // nothing enabled means nothing to combine: stays inactive
        if (n_en != 3'h0)
        begin
            case (c.code)
                COMB_AND:  res = (n_act == n_en);
                COMB_NAND: res = (n_act != n_en);
                COMB_OR:   res = (n_act != 3'h0);
                COMB_NOR:  res = (n_act == 3'h0);
                COMB_XOR:  res = (n_act == 3'h1);
                default:   res = 1'b0;
            endcase
        end
        return res;
    endfunction

    // detectors, each with its own configuration
    for (genvar j = 0; j < NUM_DET; j++)
    begin : g_det
        level_detector u_det
        (
            .sys_clk         (sys_clk),
            .rst             (rst),
            .half_cycle_tick (half_cycle_tick),
            .rms             (rms_in[j]),
            .cfg             (state_r.det_cfg[j]),
            .alarm           (det_alarm_w[j])
        );
    end

    assign alarm_all = {det_alarm_w, state_r.comb_alarm};
    assign rise_ev   = alarm_all & ~state_r.prev_alarm;
    assign fall_ev   = ~alarm_all & state_r.prev_alarm;
    assign setup     = apb_req.psel & !apb_req.penable;
    assign access    = apb_req.psel & apb_req.penable;
    assign wr_done   = access & apb_req.pwrite;
    assign rd_done   = access & !apb_req.pwrite;

    // clear only what the read reported, so a fresh event is never lost
    assign pick_clr  = (rd_done && apb_req.paddr == PICK_STAT) ?
                       state_r.prdata[NUM_EV-1:0] : '0;
    assign drop_clr  = (rd_done && apb_req.paddr == DROP_STAT) ?
                       state_r.prdata[NUM_EV-1:0] : '0;

    // read decode, captured in the setup cycle
    always_comb
    begin
        rd_data = '0;
        rd_hit  = 1'b0;
        for (int i = 0; i < NUM_COMB; i++)
        begin
            if (apb_req.paddr == COMB_BASE + WORD_STEP * ADDR_W'(i))
            begin
                rd_data = state_r.comb_cfg[i];
                rd_hit  = 1'b1;
            end
        end
        for (int j = 0; j < NUM_DET; j++)
        begin
            if (apb_req.paddr == DET_BASE + DET_STRIDE * ADDR_W'(j))
            begin
                rd_data = state_r.det_cfg[j][DATA_W-1:0];
                rd_hit  = 1'b1;
            end
            if (apb_req.paddr == DET_BASE + DET_STRIDE * ADDR_W'(j) + DET_DLY_OFS)
            begin
                rd_data = state_r.det_cfg[j][2*DATA_W-1:DATA_W];
                rd_hit  = 1'b1;
            end
        end
        case (apb_req.paddr)
            ALARM_STAT:
            begin
                rd_data = DATA_W'(alarm_all);
                rd_hit  = 1'b1;
            end
            PICK_STAT:
            begin
                rd_data = DATA_W'(state_r.pick_stat);
                rd_hit  = 1'b1;
            end
            PICK_MASK:
            begin
                rd_data = DATA_W'(state_r.pick_mask);
                rd_hit  = 1'b1;
            end
            DROP_STAT:
            begin
                rd_data = DATA_W'(state_r.drop_stat);
                rd_hit  = 1'b1;
            end
            DROP_MASK:
            begin
                rd_data = DATA_W'(state_r.drop_mask);
                rd_hit  = 1'b1;
            end
            EVAL_COUNT:
            begin
                rd_data = state_r.eval_count;
                rd_hit  = 1'b1;
            end
            default:
            begin
                rd_data = rd_data;
            end
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;

        // combiners run every clock, each on its own configuration
        for (int i = 0; i < NUM_COMB; i++)
        begin
            state_nxt.comb_alarm[i] = comb_eval(state_r.comb_cfg[i], alarm_src);
        end

        // edge history and sticky events; set wins over a clear
        state_nxt.prev_alarm = alarm_all;
        state_nxt.pick_stat  = (state_r.pick_stat & ~pick_clr) | rise_ev;
        state_nxt.drop_stat  = (state_r.drop_stat & ~drop_clr) | fall_ev;

        if (half_cycle_tick)
        begin
            state_nxt.eval_count = state_r.eval_count + DATA_W'(1);
        end

        // setup cycle: capture read data and the error answer
        if (setup)
        begin
            state_nxt.prdata  = apb_req.pwrite ? '0 : rd_data;
            state_nxt.pslverr = !rd_hit;
        end

        // access cycle: writes take effect
        if (wr_done)
        begin
            for (int i = 0; i < NUM_COMB; i++)
            begin
                if (apb_req.paddr == COMB_BASE + WORD_STEP * ADDR_W'(i))
                begin
                    state_nxt.comb_cfg[i] = apb_req.pwdata;
                end
            end
            for (int j = 0; j < NUM_DET; j++)
            begin
                if (apb_req.paddr == DET_BASE + DET_STRIDE * ADDR_W'(j))
                begin
                    state_nxt.det_cfg[j][DATA_W-1:0] = apb_req.pwdata;
                end
                if (apb_req.paddr == DET_BASE + DET_STRIDE * ADDR_W'(j) + DET_DLY_OFS)
                begin
                    // spare bits are kept at zero
                    state_nxt.det_cfg[j][2*DATA_W-1:DATA_W] =
                        {14'h0, apb_req.pwdata[17:0]};
                end
            end
            case (apb_req.paddr)
                PICK_MASK:
                begin
                    state_nxt.pick_mask = apb_req.pwdata[NUM_EV-1:0];
                end
                DROP_MASK:
                begin
                    state_nxt.drop_mask = apb_req.pwdata[NUM_EV-1:0];
                end
                default:
                begin
                    state_nxt.pick_mask = state_nxt.pick_mask;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_r           <= '0;
            state_r.comb_cfg  <= {NUM_COMB{CFG_RST}};
            state_r.pick_mask <= MASK_RST;
            state_r.drop_mask <= MASK_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // zero wait states: read data was captured in the setup cycle
    assign pready     = 1'b1;
    assign prdata     = state_r.prdata;
    assign pslverr    = state_r.pslverr & access;
    assign comb_alarm = state_r.comb_alarm;
    assign det_alarm  = det_alarm_w;
    assign irq        = |(state_r.pick_stat & state_r.pick_mask) |
                        |(state_r.drop_stat & state_r.drop_mask);

endmodule

/* hw/alarm_pkg.sv */
// shared constants, register map and carrier types of the alarm combiner
package alarm_pkg;

    // sizes
    localparam int NUM_COMB         = 10;
    localparam int NUM_DET          = 12;
    localparam int NUM_SRC          = 32;
    localparam int COMB_INPUTS      = 4;
    localparam int NUM_EV           = NUM_COMB + NUM_DET;
    localparam int RMS_W            = 16;
    localparam int DLY_W            = 8;
    localparam int CNT_W            = 9;
    localparam int SEL_W            = 5;
    localparam int ADDR_W           = 12;
    localparam int DATA_W           = 32;
    localparam int HALVES_PER_CYCLE = 2;

    // combine type codes (decimal 100 to 104)
    localparam logic [7:0] COMB_AND  = 8'h64;
    localparam logic [7:0] COMB_NAND = 8'h65;
    localparam logic [7:0] COMB_OR   = 8'h66;
    localparam logic [7:0] COMB_NOR  = 8'h67;
    localparam logic [7:0] COMB_XOR  = 8'h68;

    // register byte offsets
    localparam logic [ADDR_W-1:0] COMB_BASE      = 12'h000;
    localparam logic [ADDR_W-1:0] DET_BASE       = 12'h040;
    localparam logic [ADDR_W-1:0] ALARM_STAT     = 12'h0C0;
    localparam logic [ADDR_W-1:0] PICK_STAT      = 12'h0C4;
    localparam logic [ADDR_W-1:0] PICK_MASK      = 12'h0C8;
    localparam logic [ADDR_W-1:0] DROP_STAT      = 12'h0CC;
    localparam logic [ADDR_W-1:0] DROP_MASK      = 12'h0D0;
    localparam logic [ADDR_W-1:0] EVAL_COUNT     = 12'h0D4;
    localparam logic [ADDR_W-1:0] WORD_STEP      = 12'h004;
    localparam logic [ADDR_W-1:0] DET_STRIDE     = 12'h008;
    localparam logic [ADDR_W-1:0] DET_DLY_OFS    = 12'h004;

    // reset values
    localparam logic [DATA_W-1:0] CFG_RST        = 32'h0000_0000;
    localparam logic [NUM_EV-1:0] MASK_RST       = 22'h000000;

    // combiner config word: enables [31:28], selects [27:8], code [7:0]
    typedef struct packed {
        logic [COMB_INPUTS-1:0]            enable;
        logic [COMB_INPUTS-1:0][SEL_W-1:0] sel;
        logic [7:0]                        code;
    } comb_cfg_type;

    // detector config: word 0 is bits [31:0], word 1 is bits [63:32]
    typedef struct packed {
        logic [13:0]      spare;
        logic             enable;
        logic             sag;
        logic [DLY_W-1:0] drop_dly;
        logic [DLY_W-1:0] pick_dly;
        logic [RMS_W-1:0] drop_lvl;
        logic [RMS_W-1:0] pick_lvl;
    } det_cfg_type;

    // apb request from the master
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
    } apb_req_type;

endpackage

/* hw/level_detector.sv */
// one sag or swell detector with pickup and dropout delay counting
`timescale 1ns/100ps
module level_detector
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    // evaluation
    input  wire logic             half_cycle_tick,
    input  wire logic [RMS_W-1:0] rms,
    input  wire det_cfg_type      cfg,
    // result
    output logic                  alarm
);

    typedef struct packed {
        logic             alarm;
        logic [CNT_W-1:0] count;
    } det_state_type;

    det_state_type    state_r;
    det_state_type    state_nxt;
    logic             cond;
    logic [CNT_W-1:0] target;
    logic [CNT_W-1:0] count_inc;

    always_comb
    begin
        state_nxt = state_r;
        count_inc = state_r.count + CNT_W'(1);
        // delays in whole cycles, counted as half-cycle evaluations
        target    = CNT_W'(HALVES_PER_CYCLE) *
                    (state_r.alarm ? CNT_W'(cfg.drop_dly) : CNT_W'(cfg.pick_dly));
        // magnitudes compared unsigned
        if (state_r.alarm)
        begin
            cond = cfg.sag ? (rms > cfg.drop_lvl)
                           : (rms < cfg.drop_lvl);
        end
        else
        begin
            cond = cfg.sag ? (rms < cfg.pick_lvl)
                           : (rms > cfg.pick_lvl);
        end
        if (!cfg.enable)
        begin
            state_nxt.alarm = 1'b0;
            state_nxt.count = '0;
        end
        else if (half_cycle_tick)
        begin
            if (!cond)
            begin
                state_nxt.count = '0;
            end
            else if (count_inc >= target)
            begin
                state_nxt.alarm = !state_r.alarm;
                state_nxt.count = '0;
            end
            else
            begin
                state_nxt.count = count_inc;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            state_r <= '0;
        else
            state_r <= state_nxt;
    end

    assign alarm = state_r.alarm;

endmodule

/* testbench/alarm_assertions.sv */
// port checker for the alarm combiner, bound to its top module
`timescale 1ns/100ps
module alarm_assertions
    import alarm_pkg::*;
(
    // clock and reset
    input wire logic                          sys_clk,
    input wire logic                          rst,
    // apb
    input wire apb_req_type                   apb_req,
    input wire logic [DATA_W-1:0]             prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    // core side and results
    input wire logic                          half_cycle_tick,
    input wire logic [NUM_DET-1:0][RMS_W-1:0] rms_in,
    input wire logic [NUM_SRC-1:0]            alarm_src,
    input wire logic [NUM_COMB-1:0]           comb_alarm,
    input wire logic [NUM_DET-1:0]            det_alarm,
    input wire logic                          irq
);
    logic              acc;
    logic              wr;
    logic [ADDR_W-1:0] a;
    assign acc = apb_req.psel && apb_req.penable;
    assign wr  = acc && apb_req.pwrite;
    assign a   = apb_req.paddr;

    ready_high_a: assert property (@(posedge sys_clk) disable iff (rst) pready)
        else $error("pready low");
    err_in_access_a: assert property (@(posedge sys_clk) disable iff (rst) !acc |-> !pslverr)
        else $error("pslverr outside access");
    err_single_a: assert property (@(posedge sys_clk) disable iff (rst) pslverr |=> !pslverr)
        else $error("pslverr held");
    unmapped_err_a: assert property (@(posedge sys_clk) disable iff (rst)
        acc && (a >= 12'h0D8 || (a >= 12'h028 && a < 12'h040)) |-> pslverr && prdata == 32'h0)
        else $error("unmapped not refused");
    mapped_ok_a: assert property (@(posedge sys_clk) disable iff (rst)
        acc && (a < 12'h028 || (a >= 12'h040 && a < 12'h0A0)) && a[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped refused");
    reset_clear_a: assert property (@(posedge sys_clk) rst |=>
        comb_alarm == '0 && det_alarm == '0 && !irq && !pslverr) else $error("reset state");
    det_on_tick_a: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(det_alarm) |-> $past(half_cycle_tick) || $past(wr) || $past(wr, 2))
        else $error("detector moved off tick");
    comb_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
        $changed(comb_alarm) |-> $past(alarm_src) != $past(alarm_src, 2) || $past(wr, 2))
        else $error("combiner moved without cause");
endmodule

bind alarm_combiner alarm_assertions i_chk (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .half_cycle_tick(half_cycle_tick),
    .rms_in(rms_in), .alarm_src(alarm_src), .comb_alarm(comb_alarm), .det_alarm(det_alarm),
    .irq(irq));

/* testbench/meter_core_model.sv */
// metering core model: half-cycle tick, rms results, basic alarm states
`timescale 1ns/100ps
module meter_core_model
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // values commanded by the bench
    input  wire logic [NUM_DET-1:0][RMS_W-1:0] rms_set,
    input  wire logic [NUM_SRC-1:0]            src_set,
    // toward the block
    output logic                               half_cycle_tick,
    output logic [NUM_DET-1:0][RMS_W-1:0]      rms_in,
    output logic [NUM_SRC-1:0]                 alarm_src
);
    logic [2:0] phase_r;
    always_ff @(posedge sys_clk)
    begin
        phase_r <= rst ? 3'h0 : phase_r + 3'h1;
        // one pulse per eight clocks stands in for a half line cycle
        half_cycle_tick <= !rst && phase_r == 3'h6;
        // rms refreshed well before the tick so it is stable when sampled
        if (phase_r == 3'h3)
            rms_in <= rms_set;
        alarm_src <= src_set;
    end
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the alarm combiner
`timescale 1ns/100ps
module tb_top;
    import alarm_pkg::*;
    logic                          sys_clk, rst, half_cycle_tick, pready, pslverr, irq, err;
    apb_req_type                   apb_req;
    logic [DATA_W-1:0]             prdata, rd, ev;
    logic [NUM_DET-1:0][RMS_W-1:0] rms_set, rms_in;
    logic [NUM_SRC-1:0]            src_set, alarm_src;
    logic [NUM_COMB-1:0]           comb_alarm, ce;
    logic [NUM_DET-1:0]            det_alarm, ref_alarm, seen, dseen;
    comb_cfg_type                  ccfg [NUM_COMB];
    det_cfg_type                   dcfg [NUM_DET];
    int                            cnt [NUM_DET];
    int                            n_fail, check_count, t;
    logic [RMS_W-1:0]              lv [5] = '{16'h01C2, 16'h01F4, 16'h02EE, 16'h03E8, 16'h041A};

    alarm_combiner i_dut (.sys_clk(sys_clk), .rst(rst), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .half_cycle_tick(half_cycle_tick),
        .rms_in(rms_in), .alarm_src(alarm_src), .comb_alarm(comb_alarm),
        .det_alarm(det_alarm), .irq(irq));
    meter_core_model i_core (.sys_clk(sys_clk), .rst(rst), .rms_set(rms_set),
        .src_set(src_set), .half_cycle_tick(half_cycle_tick), .rms_in(rms_in),
        .alarm_src(alarm_src));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // leading edge keeps the release of the last transfer apart from this setup
    task automatic apb(input int adr, input logic w, input logic [31:0] d);
        @(posedge sys_clk);
        apb_req <= '{ADDR_W'(adr), 1'b1, 1'b0, w, d};
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask

    function automatic logic comb_exp(comb_cfg_type c, logic [NUM_SRC-1:0] s);
        int n = 0;
        int m = 0;
        for (int k = 0; k < COMB_INPUTS; k++)
        begin
            m += c.enable[k];
            n += c.enable[k] && s[c.sel[k]];
        end
        if (m == 0)
            return 1'b0;
        case (c.code)
            COMB_AND:  return n == m;
            COMB_NAND: return n != m;
            COMB_OR:   return n != 0;
            COMB_NOR:  return n == 0;
            COMB_XOR:  return n == 1;
            default:   return 1'b0;
        endcase
    endfunction

    task automatic det_step();
        for (int j = 0; j < NUM_DET; j++)
        begin
            logic c;
            logic [RMS_W-1:0] v;
            v = rms_in[j];
            if (ref_alarm[j])
                c = dcfg[j].sag ? v > dcfg[j].drop_lvl : v < dcfg[j].drop_lvl;
            else
                c = dcfg[j].sag ? v < dcfg[j].pick_lvl : v > dcfg[j].pick_lvl;
            cnt[j] = c ? cnt[j] + 1 : 0;
            if (c && cnt[j] >= 2 * (ref_alarm[j] ? dcfg[j].drop_dly : dcfg[j].pick_dly))
            begin
                seen[j] = seen[j] | !ref_alarm[j];
                dseen[j] = dseen[j] | ref_alarm[j];
                ref_alarm[j] = !ref_alarm[j];
                cnt[j] = 0;
            end
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        results();
    end

    initial
    begin
        void'($urandom(64801));
        rst = 1'b1;
        apb_req = '0;
        src_set = '0;
        rms_set = {NUM_DET{16'h02EE}};
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        apb(PICK_MASK, 1'b0, 32'h0);
        check("mask reset", {10'h0, MASK_RST}, rd);
        apb(12'h0D8, 1'b0, 32'h0);
        check("unmapped err", 32'h1, {31'h0, err});
        apb(12'h028, 1'b0, 32'h0);
        check("gap err", 32'h1, {31'h0, err});
        apb(PICK_MASK, 1'b1, 32'h003FFC00);
        apb(PICK_MASK, 1'b0, 32'h0);
        check("mask", 32'h003FFC00, rd);
        apb(DROP_MASK, 1'b1, 32'h003FFC00);
        apb(DROP_MASK, 1'b0, 32'h0);
        check("drop mask", 32'h003FFC00, rd);
        for (int r = 0; r < 4; r++)
        begin
            for (int i = 0; i < NUM_COMB; i++)
            begin
                ccfg[i] = $urandom;
                ccfg[i].code = COMB_AND + 8'((i + r) % 5);
                // first round with all inputs enabled, later ones random
                if (r == 0)
                    ccfg[i].enable = 4'hF;
                apb(COMB_BASE + 4 * i, 1'b1, ccfg[i]);
            end
            repeat (25)
            begin
                src_set <= $urandom;
                repeat (3) @(posedge sys_clk);
                for (int i = 0; i < NUM_COMB; i++)
                begin
                    ce[i] = comb_exp(ccfg[i], src_set);
                    check("comb", 32'(ce[i]), 32'(comb_alarm[i]));
                end
            end
        end
        apb(ALARM_STAT, 1'b0, 32'h0);
        check("status", {22'h0, ce}, rd);
        for (int j = 0; j < NUM_DET; j++)
        begin
            dcfg[j] = {14'h0, 1'b1, j[0], 8'($urandom_range(3)), 8'($urandom_range(3)),
                       j[0] ? {16'h0258, 16'h01F4} : {16'h0384, 16'h03E8}};
            apb(DET_BASE + 8 * j, 1'b1, dcfg[j][31:0]);
            apb(DET_BASE + 8 * j + 4, 1'b1, dcfg[j][63:32]);
        end
        apb(PICK_STAT, 1'b0, 32'h0);
        ref_alarm = '0;
        seen = '0;
        dseen = '0;
        cnt = '{default: 0};
        for (t = 1; t <= 240; t++)
        begin
            do
                @(posedge sys_clk);
            while (half_cycle_tick !== 1'b1);
            det_step();
            // levels persist for a few ticks so delays can complete
            for (int j = 0; j < NUM_DET; j++)
                if ($urandom_range(3) == 0)
                    rms_set[j] <= lv[$urandom_range(4)];
            #1;
            check("det", 32'(ref_alarm), 32'(det_alarm));
            if (t % 16 == 0)
            begin
                @(posedge sys_clk);
                #1;
                check("irq", 32'(|{seen, dseen}), 32'(irq));
                apb(PICK_STAT, 1'b0, 32'h0);
                check("pick stat", 32'(seen), 32'(rd[21:10]));
                apb(DROP_STAT, 1'b0, 32'h0);
                check("drop stat", 32'(dseen), 32'(rd[21:10]));
                seen = '0;
                dseen = '0;
            end
            // tick counter read between ticks: sixteen ticks per period
            if (t % 16 == 8)
            begin
                apb(EVAL_COUNT, 1'b0, 32'h0);
                if (t > 8)
                    check("tick count", ev + 32'h10, rd);
                ev = rd;
            end
        end
        results();
    end
endmodule
